// ### bench/hcu_host.sv
/* Host side model: sends and receives serial frames. Assumes calls at a rising edge. */
`timescale 1ns/10ps
module hcu_host #(parameter int CPB = 16)
(
	input wire core_clk,
	input wire ser_out,
	output logic ser_in = 1'b1,
	output logic [8:0] rx_byte = 9'h000,
	output logic rx_valid = 1'b0
);
	task send(input logic [7:0] b, input logic stp);
		logic [9:0] f;
		f = {stp, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			ser_in <= f[i];
			repeat (CPB) @(posedge core_clk);
		end
		ser_in <= 1'b1;
		@(posedge core_clk);
	endtask
	always
	begin
		@(negedge ser_out);
		repeat (CPB / 2) @(posedge core_clk);
		for (int i = 0; i < 9; i++)
		begin
			repeat (CPB) @(posedge core_clk);
			rx_byte[i] <= ser_out;
		end
		rx_valid <= 1'b1;
		@(posedge core_clk);
		rx_valid <= 1'b0;
	end
endmodule // hcu_host

// ### bench/hcu_uart_monitor.sv
/* Port checker for hcu_uart. Assumes the bind below and CPB equal to CLKS_PER_BIT. */
`timescale 1ns/10ps
module hcu_uart_monitor #(parameter int CPB = 16)
(
	input wire core_clk,
	input wire sys_rst,
	input wire tx_valid,
	input wire tx_ready,
	input wire ser_out_r,
	input wire payload_valid_r,
	input wire cmd_char_valid_r,
	input wire cmd_end_r,
	input wire boot_active_r,
	input wire boot_update_r
);
	localparam int FRM = 10 * CPB - 1;
	localparam int STP = 9 * CPB;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_tx_start: assert property (tx_valid && tx_ready |=> !ser_out_r && !tx_ready)
		else $error("start bit missing");
	a_idle_high: assert property (tx_ready |-> ser_out_r)
		else $error("line not idle high");
	a_frame_len: assert property ($fell(tx_ready) |-> ##FRM !tx_ready ##1 tx_ready)
		else $error("frame length wrong");
	a_stop_bit: assert property ($fell(tx_ready) |-> ##STP ser_out_r [*8])
		else $error("stop bit low");
	a_pay_pulse: assert property (payload_valid_r |=> !payload_valid_r)
		else $error("payload pulse long");
	a_cmd_pulse: assert property (cmd_char_valid_r || cmd_end_r |=> !cmd_char_valid_r && !cmd_end_r)
		else $error("command pulse long");
	a_boot_quiet: assert property (boot_active_r |-> !payload_valid_r && !cmd_char_valid_r)
		else $error("decoder active in boot");
	a_boot_over: assert property (!boot_active_r |=> !boot_active_r)
		else $error("boot window reopened");
	a_upd_sticky: assert property (boot_update_r |=> boot_update_r)
		else $error("update flag lost");
endmodule // hcu_uart_monitor
bind hcu_uart hcu_uart_monitor #(.CPB(CLKS_PER_BIT)) i_hcu_uart_monitor (.core_clk(core_clk),
	.sys_rst(sys_rst), .tx_valid(tx_valid), .tx_ready(tx_ready), .ser_out_r(ser_out_r),
	.payload_valid_r(payload_valid_r), .cmd_char_valid_r(cmd_char_valid_r),
	.cmd_end_r(cmd_end_r), .boot_active_r(boot_active_r), .boot_update_r(boot_update_r));

// ### bench/hcu_uart_tb.sv
/* Testbench of hcu_uart with host model. Assumes CLKS_PER_BIT 16, BOOT_CYCLES 3000. */
`timescale 1ns/10ps
module hcu_uart_tb;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic low_energy_wait = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_valid = 1'b0;
	wire ser_in, ser_out_r, tx_ready, payload_valid_r, cmd_char_valid_r, cmd_end_r;
	wire frame_err_r, wake_r, boot_active_r, boot_update_r, hrv;
	wire [7:0] payload_data_r, cmd_char_r;
	wire [8:0] hrx;
	logic [10:0] exq[$];
	int n_mismatch = 0, n_tests = 0, n_ferr = 0, n_wake = 0, cyc = 0, seed;
	logic [7:0] r;
	always #50 core_clk = ~core_clk;
	hcu_uart #(.CLKS_PER_BIT(16), .BOOT_CYCLES(3000)) i_hcu_uart (.core_clk(core_clk),
		.sys_rst(sys_rst), .ser_in(ser_in), .ser_out_r(ser_out_r),
		.low_energy_wait(low_energy_wait), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .payload_data_r(payload_data_r), .payload_valid_r(payload_valid_r),
		.cmd_char_r(cmd_char_r), .cmd_char_valid_r(cmd_char_valid_r), .cmd_end_r(cmd_end_r),
		.frame_err_r(frame_err_r), .wake_r(wake_r), .boot_active_r(boot_active_r),
		.boot_update_r(boot_update_r));
	hcu_host #(.CPB(16)) i_hcu_host (.core_clk(core_clk), .ser_out(ser_out_r),
		.ser_in(ser_in), .rx_byte(hrx), .rx_valid(hrv));
	task final_report;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task cmp(input logic got, input logic want);
		n_tests++;
		if (got !== want)
		begin
			n_mismatch++;
			$display("[FAIL] %0t flag %b not %b", $time, got, want);
		end
	endtask
	task chk(input logic [10:0] got);
		n_tests++;
		if (exq.size() == 0 || got !== exq[0])
		begin
			n_mismatch++;
			$display("[FAIL] %0t result %h unexpected", $time, got);
		end
		if (exq.size() > 0)
			void'(exq.pop_front());
	endtask
	task line(input string s, input logic [1:0] k);
		foreach (s[i])
		begin
			if (k != 2'h3)
				exq.push_back({k, 1'b0, s[i]});
			i_hcu_host.send(s[i], 1'b1);
		end
	endtask
	always @(posedge core_clk)
	begin
		cyc++;
		if (payload_valid_r)
			chk({3'h0, payload_data_r});
		if (cmd_char_valid_r)
			chk({3'h2, cmd_char_r});
		if (cmd_end_r)
			chk(11'h40D);
		if (hrv)
			chk({2'h3, hrx});
		n_ferr += frame_err_r;
		n_wake += wake_r;
		if (cyc == 12000)
		begin
			n_mismatch++;
			final_report;
		end
	end
	initial
	begin
		seed = 68;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		line("AU", 2'h3);
		repeat (4) @(posedge core_clk);
		cmp(boot_update_r, 1'b1);
		sys_rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (2990) @(posedge core_clk);
		cmp(boot_active_r, 1'b1);
		repeat (20) @(posedge core_clk);
		cmp(boot_active_r | boot_update_r, 1'b0);
		$display("boot done");
		line("aT", 2'h3);
		line("1", 2'h1);
		exq.push_back(11'h258);
		line("x", 2'h3);
		exq.push_back(11'h40D);
		line("\r", 2'h3);
		line("A", 2'h3);
		line("Q\np", 2'h0);
		repeat (4)
		begin
			r = $random(seed) | 8'h80;
			exq.push_back({3'h0, r});
			i_hcu_host.send(r, 1'b1);
		end
		line("\r", 2'h0);
		$display("lines done");
		i_hcu_host.send(8'h5A, 1'b0);
		repeat (32) @(posedge core_clk);
		cmp(n_ferr == 1, 1'b1);
		low_energy_wait <= 1'b1;
		line("z\r", 2'h0);
		low_energy_wait <= 1'b0;
		cmp(n_wake == 2, 1'b1);
		$display("receive done");
		repeat (2)
		begin
			r = $random(seed);
			exq.push_back({3'h7, r});
			tx_data <= r;
			tx_valid <= 1'b1;
			@(posedge core_clk);
			while (tx_ready !== 1'b1)
				@(posedge core_clk);
		end
		tx_valid <= 1'b0;
		wait (exq.size() == 0);
		$display("transmit done");
		final_report;
	end
endmodule // hcu_uart_tb

// ### core/hcu_pin_sync.v
/*
 * Three-stage synchroniser for an asynchronous pin with agreement filter.
 * Assumes the pin is held high by a pull-up when undriven.
 */
`timescale 1ns/10ps
module hcu_pin_sync
(
	input wire core_clk,
	input wire sys_rst,
	input wire pin_in,
	output reg level_r
);

	reg s1_r;
	reg s2_r;
	reg s3_r;

	// ****************************************
	// Sync chain
	// ****************************************
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			level_r <= 1'b1;
		end
		else
		begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// Change accepted once stages two and three agree
			if (s2_r == s3_r)
				level_r <= s3_r;
		end
	end

endmodule // hcu_pin_sync

// ### core/hcu_uart.v
/*
 * Host command serial port: 9600 8N1 transmitter and receiver, boot
 * window watching for an update key, and command line splitter.
 * Assumes the serial input pin has a pull-up and that the user side
 * raises tx_valid only with stable tx_data.
 */
`timescale 1ns/10ps
`include "hcu_consts.vh"

// Summary of operation
// - 9600 baud, eight data, one stop
// - Only two lines, no flow control
// - Device drives its serial output line
// - ASCII commands, answers and payload share link
// - Decode command lines for peripheral control
// - Receiver stays live during low-energy wait
// - Both lines idle high: input via pull-up, output driven high
// - 200 ms boot window watches update condition
module hcu_uart
#(
	parameter CLKS_PER_BIT = `HCU_CLKS_PER_BIT,
	parameter BOOT_CYCLES = `HCU_BOOT_CYCLES,
	parameter [7:0] UPDATE_KEY = `HCU_CH_UPDATE
)
(
	input wire core_clk,
	input wire sys_rst,
	input wire ser_in,
	output reg ser_out_r,
	input wire low_energy_wait,
	input wire [7:0] tx_data,
	input wire tx_valid,
	output wire tx_ready,
	output reg [7:0] payload_data_r,
	output reg payload_valid_r,
	output reg [7:0] cmd_char_r,
	output reg cmd_char_valid_r,
	output reg cmd_end_r,
	output reg frame_err_r,
	output reg wake_r,
	output reg boot_active_r,
	output reg boot_update_r
);

	localparam CNT_W = $clog2(CLKS_PER_BIT + 1);
	localparam BOOT_W = $clog2(BOOT_CYCLES + 1);
	localparam [31:0] CPB_32 = CLKS_PER_BIT;
	localparam [31:0] BOOT_32 = BOOT_CYCLES;
	localparam [31:0] DATA_LAST = `HCU_DATA_BITS - 1;
	localparam [CNT_W-1:0] BIT_LAST = CPB_32[CNT_W-1:0] - 1'b1;
	localparam [CNT_W-1:0] HALF_LAST = (CPB_32[CNT_W-1:0] >> 1) - 1'b1;
	localparam [BOOT_W-1:0] BOOT_LAST = BOOT_32[BOOT_W-1:0] - 1'b1;
	localparam [2:0] LAST_BIT = DATA_LAST[2:0];

	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_START = 2'h1;
	localparam [1:0] S_DATA = 2'h2;
	localparam [1:0] S_STOP = 2'h3;

	localparam [1:0] D_SOL = 2'h0;
	localparam [1:0] D_PFX = 2'h1;
	localparam [1:0] D_CMD = 2'h2;
	localparam [1:0] D_PAY = 2'h3;

	// Upper-case fold for letters
	function [7:0] hcu_upper;
		input [7:0] c;
		begin
			if (c >= 8'h61 && c <= 8'h7A)
				hcu_upper = c & ~`HCU_CASE_BIT;
			else
				hcu_upper = c;
		end
	endfunction

	function hcu_is_eol;
		input [7:0] c;
		begin
			hcu_is_eol = (c == `HCU_CH_CR) || (c == `HCU_CH_LF);
		end
	endfunction

	wire rx_lvl;
	reg [1:0] tx_st_r;
	reg [CNT_W-1:0] tx_cnt_r;
	reg [2:0] tx_bit_r;
	reg [7:0] tx_sh_r;
	reg [1:0] rx_st_r;
	reg [CNT_W-1:0] rx_cnt_r;
	reg [2:0] rx_bit_r;
	reg [7:0] rx_sh_r;
	reg rx_done_r;
	reg [7:0] rx_byte_r;
	reg [BOOT_W-1:0] boot_cnt_r;
	reg [1:0] dec_st_r;

	// ****************************************
	// Serial input synchroniser
	// ****************************************
	// sample host line
	hcu_pin_sync u_rx_sync
	(
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.pin_in(ser_in),
		.level_r(rx_lvl)
	);

	// ****************************************
	// Transmitter
	// ****************************************
	// no handshake, only own state
	assign tx_ready = (tx_st_r == S_IDLE);

	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			tx_st_r <= S_IDLE;
			tx_cnt_r <= {CNT_W{1'b0}};
			tx_bit_r <= 3'h0;
			tx_sh_r <= 8'h00;
			ser_out_r <= 1'b1;
		end
		else
		begin
			if (tx_st_r != S_IDLE)
				tx_cnt_r <= (tx_cnt_r == BIT_LAST) ? {CNT_W{1'b0}} : tx_cnt_r + 1'b1;
			case (tx_st_r)
				S_IDLE:
				begin
					ser_out_r <= 1'b1;
					if (tx_valid)
					begin
						tx_sh_r <= tx_data;
						tx_cnt_r <= {CNT_W{1'b0}};
						ser_out_r <= 1'b0;
						tx_st_r <= S_START;
					end
				end
				S_START:
				begin
					if (tx_cnt_r == BIT_LAST)
					begin
						ser_out_r <= tx_sh_r[0];
						tx_sh_r <= {1'b0, tx_sh_r[7:1]};
						tx_bit_r <= 3'h0;
						tx_st_r <= S_DATA;
					end
				end
				S_DATA:
				begin
					if (tx_cnt_r == BIT_LAST)
					begin
						if (tx_bit_r == LAST_BIT)
						begin
							ser_out_r <= 1'b1;
							tx_st_r <= S_STOP;
						end
						else
						begin
							ser_out_r <= tx_sh_r[0];
							tx_sh_r <= {1'b0, tx_sh_r[7:1]};
							tx_bit_r <= tx_bit_r + 3'h1;
						end
					end
				end
				default:
				begin
					if (tx_cnt_r == BIT_LAST)
						tx_st_r <= S_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	// runs regardless of low-energy wait
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			rx_st_r <= S_IDLE;
			rx_cnt_r <= {CNT_W{1'b0}};
			rx_bit_r <= 3'h0;
			rx_sh_r <= 8'h00;
			rx_done_r <= 1'b0;
			rx_byte_r <= 8'h00;
			frame_err_r <= 1'b0;
			wake_r <= 1'b0;
		end
		else
		begin
			rx_done_r <= 1'b0;
			frame_err_r <= 1'b0;
			wake_r <= 1'b0;
			rx_cnt_r <= (rx_cnt_r == BIT_LAST) ? {CNT_W{1'b0}} : rx_cnt_r + 1'b1;
			case (rx_st_r)
				S_IDLE:
				begin
					rx_cnt_r <= {CNT_W{1'b0}};
					if (!rx_lvl)
					begin
						wake_r <= low_energy_wait;
						rx_st_r <= S_START;
					end
				end
				S_START:
				begin
					if (rx_cnt_r == HALF_LAST)
					begin
						rx_cnt_r <= {CNT_W{1'b0}};
						rx_bit_r <= 3'h0;
						rx_st_r <= rx_lvl ? S_IDLE : S_DATA;
					end
				end
				S_DATA:
				begin
					if (rx_cnt_r == BIT_LAST)
					begin
						rx_sh_r <= {rx_lvl, rx_sh_r[7:1]};
						rx_bit_r <= rx_bit_r + 3'h1;
						if (rx_bit_r == LAST_BIT)
							rx_st_r <= S_STOP;
					end
				end
				default:
				begin
					if (rx_cnt_r == BIT_LAST)
					begin
						if (rx_lvl)
						begin
							rx_byte_r <= rx_sh_r;
							rx_done_r <= 1'b1;
						end
						else
							frame_err_r <= 1'b1;
						rx_st_r <= S_IDLE;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Boot window
	// ****************************************
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			boot_cnt_r <= {BOOT_W{1'b0}};
			boot_active_r <= 1'b1;
			boot_update_r <= 1'b0;
		end
		else if (boot_active_r)
		begin
			boot_cnt_r <= boot_cnt_r + 1'b1;
			if (rx_done_r && rx_byte_r == UPDATE_KEY)
				boot_update_r <= 1'b1;
			if (boot_cnt_r == BOOT_LAST)
				boot_active_r <= 1'b0;
		end
	end

	// ****************************************
	// Line decoder
	// ****************************************
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			dec_st_r <= D_SOL;
			payload_data_r <= 8'h00;
			payload_valid_r <= 1'b0;
			cmd_char_r <= 8'h00;
			cmd_char_valid_r <= 1'b0;
			cmd_end_r <= 1'b0;
		end
		else
		begin
			payload_valid_r <= 1'b0;
			cmd_char_valid_r <= 1'b0;
			cmd_end_r <= 1'b0;
			// normal operation only after window, no update
			if (rx_done_r && !boot_active_r && !boot_update_r)
			begin
				if (hcu_is_eol(rx_byte_r))
				begin
					cmd_end_r <= (dec_st_r == D_CMD);
					payload_data_r <= rx_byte_r;
					payload_valid_r <= (dec_st_r == D_PAY);
					dec_st_r <= D_SOL;
				end
				else
				begin
					case (dec_st_r)
						D_SOL:
						begin
							if (hcu_upper(rx_byte_r) == `HCU_CH_PREFIX0)
								dec_st_r <= D_PFX;
							else
							begin
								payload_data_r <= rx_byte_r;
								payload_valid_r <= 1'b1;
								dec_st_r <= D_PAY;
							end
						end
						D_PFX:
						begin
							if (hcu_upper(rx_byte_r) == `HCU_CH_PREFIX1)
								dec_st_r <= D_CMD;
							else
							begin
								payload_data_r <= rx_byte_r;
								payload_valid_r <= 1'b1;
								dec_st_r <= D_PAY;
							end
						end
						D_CMD:
						begin
							cmd_char_r <= hcu_upper(rx_byte_r);
							cmd_char_valid_r <= 1'b1;
						end
						default:
						begin
							payload_data_r <= rx_byte_r;
							payload_valid_r <= 1'b1;
						end
					endcase
				end
			end
		end
	end

endmodule // hcu_uart

// ### pkg/hcu_consts.vh
/*
 * Constants of the host command serial port: line timing, frame shape,
 * boot window and the characters that the line decoder recognises.
 * Assumes a single 10 MHz core clock.
 */
`ifndef HCU_CONSTS_VH
`define HCU_CONSTS_VH

// ****************************************
// Clock and line rate
// ****************************************
`define HCU_CLK_HZ 10000000
`define HCU_BAUD 9600
// Cycles per bit, rounded to nearest (1042)
`define HCU_CLKS_PER_BIT ((`HCU_CLK_HZ + (`HCU_BAUD / 2)) / `HCU_BAUD)

// ****************************************
// Frame shape
// ****************************************
`define HCU_DATA_BITS 8
`define HCU_STOP_BITS 1

// ****************************************
// Boot window after reset
// ****************************************
`define HCU_BOOT_MS 200
`define HCU_BOOT_CYCLES ((`HCU_CLK_HZ / 1000) * `HCU_BOOT_MS)

// ****************************************
// Characters
// ****************************************
`define HCU_CH_CR 8'h0D
`define HCU_CH_LF 8'h0A
`define HCU_CH_PREFIX0 8'h41
`define HCU_CH_PREFIX1 8'h54
`define HCU_CASE_BIT 8'h20
`define HCU_CH_UPDATE 8'h55

`endif
